// *** hw/flash_rewrite_pkg.sv ***
// constants shared by the flash rewrite controller, the device model and the testbench
// assumes a 25 MHz system clock and a device register port with 32-bit words
package flash_rewrite_pkg;

    localparam int CLK_HZ             = 25_000_000;
    localparam int CMD_TIMEOUT_MS     = 100;
    localparam int CMD_TIMEOUT_CYCLES = CMD_TIMEOUT_MS * (CLK_HZ / 1000);

    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int FADDR_W = 24;
    localparam int TIMER_W = 24;
    localparam int RETRY_W = 4;
    localparam int PIN_W   = 3;

    // device register offsets
    localparam logic [ADDR_W-1:0] REWRITE_OFS  = 8'h00;
    localparam logic [ADDR_W-1:0] MODE0_OFS    = 8'h04;
    localparam logic [ADDR_W-1:0] MODE1_OFS    = 8'h08;
    localparam logic [ADDR_W-1:0] STATUS_OFS   = 8'h0C;
    localparam logic [ADDR_W-1:0] DF_MODE_OFS  = 8'h10;
    localparam logic [ADDR_W-1:0] CMD_ADDR_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] CMD_DATA_OFS = 8'h18;
    localparam logic [ADDR_W-1:0] CMD_OP_OFS   = 8'h1C;

    // register fields
    localparam logic [DATA_W-1:0] RW_EN_MASK  = 32'h0000_0001;
    localparam logic [DATA_W-1:0] PE_EN_MASK  = 32'h0000_0001;
    localparam logic [DATA_W-1:0] UNLOCK_MASK = 32'h0000_0001;
    localparam logic [DATA_W-1:0] READY_MASK  = 32'h0000_0001;
    localparam logic [DATA_W-1:0] ERROR_MASK  = 32'h0000_0002;
    localparam logic [DATA_W-1:0] ZERO_WORD   = 32'h0000_0000;

    // pin positions in the synchronised group
    localparam int PIN_ABORT = 0;
    localparam int PIN_LOSPD = 1;
    localparam int PIN_LOPWR = 2;

    localparam logic [1:0] OP_PROGRAM = 2'h0;
    localparam logic [1:0] OP_ERASE   = 2'h1;
    localparam logic [1:0] OP_LOCK    = 2'h2;
    localparam logic [1:0] OP_PROTECT = 2'h3;

    localparam logic [2:0] FAIL_NONE    = 3'h0;
    localparam logic [2:0] FAIL_LOWPWR  = 3'h1;
    localparam logic [2:0] FAIL_DFLASH  = 3'h2;
    localparam logic [2:0] FAIL_VECTOR  = 3'h3;
    localparam logic [2:0] FAIL_PROTECT = 3'h4;
    localparam logic [2:0] FAIL_DEVICE  = 3'h5;
    localparam logic [2:0] FAIL_TIMEOUT = 3'h6;
    localparam logic [2:0] FAIL_ABORTS  = 3'h7;

    typedef enum logic [3:0] {
        S_IDLE    = 4'h0,
        S_CHK     = 4'h1,
        S_CHK_RD  = 4'h2,
        S_ENABLE  = 4'h3,
        S_MODE    = 4'h4,
        S_LBD     = 4'h5,
        S_ADDR    = 4'h6,
        S_DATA    = 4'h7,
        S_OP      = 4'h8,
        S_POLL    = 4'h9,
        S_POLL_RD = 4'hA,
        S_ABORT   = 4'hB,
        S_FINISH  = 4'hC,
        S_DF      = 4'hD
    } state_type;

endpackage : flash_rewrite_pkg

// *** hw/flash_pin_sync.sv ***
// two-flop synchroniser for a group of pins from the device
// assumes each pin is a slow level; bits are not coherent with each other
`timescale 1ns/1ns
`default_nettype none
module flash_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_type;

    sync_type q;
    sync_type next_q;

    always_comb
    begin
        next_q.stage1 = pin;
        next_q.stage2 = q.stage1;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            q <= '0;
        else if (ce)
            q <= next_q;
    end

    assign level = q.stage2;

endmodule : flash_pin_sync
`default_nettype wire

// *** hw/flash_rewrite_control.sv ***
// host controller that runs flash rewrite commands through the device registers
// assumes a device port that writes on dev_wr and returns read data in the dev_rd cycle
`timescale 1ns/1ns
`default_nettype none
module flash_rewrite_control
    import flash_rewrite_pkg::*;
#(
    parameter int                 TIMEOUT_CYCLES = CMD_TIMEOUT_CYCLES,
    parameter int                 MAX_RETRY      = 2,
    parameter logic [FADDR_W-1:0] CTRL_BLK_LO    = 24'hFF0000,
    parameter logic [FADDR_W-1:0] CTRL_BLK_HI    = 24'hFFFFFF
) (
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic               ce,
    input  wire logic               cmd_valid,
    output logic                    cmd_ready,
    input  wire logic [1:0]         cmd_op,
    input  wire logic               cmd_mode,
    input  wire logic [FADDR_W-1:0] cmd_addr,
    input  wire logic [DATA_W-1:0]  cmd_data,
    input  wire logic               df_req,
    input  wire logic               df_enable,
    output logic                    df_ready,
    input  wire logic               vec_in_ram,
    input  wire logic               rst_req,
    output logic                    done,
    output logic [2:0]              fail,
    output logic                    aborted,
    output logic                    busy,
    output logic                    rewrite_on,
    output logic                    trap_inhibit,
    output logic                    vec_irq_mask,
    output logic                    wdt_allow,
    output logic [ADDR_W-1:0]       dev_addr,
    output logic [DATA_W-1:0]       dev_wdata,
    output logic                    dev_wr,
    output logic                    dev_rd,
    input  wire logic [DATA_W-1:0]  dev_rdata,
    output logic                    dev_reset_n,
    input  wire logic               abort_irq,
    input  wire logic               low_speed,
    input  wire logic               low_power
);

    typedef struct packed {
        state_type          st;
        logic [1:0]         op;
        logic [1:0]         cur_op;
        logic               mode;
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0]  data;
        logic               rw_on;
        logic               recover;
        logic [RETRY_W-1:0] retries;
        logic [TIMER_W-1:0] timer;
        logic [ADDR_W-1:0]  dev_addr;
        logic [DATA_W-1:0]  dev_wdata;
        logic               dev_wr;
        logic               dev_rd;
        logic               dev_reset_n;
        logic               done;
        logic [2:0]         fail;
        logic               aborted;
    } ctrl_type;

    localparam ctrl_type CTRL_RESET = '{st: S_IDLE, dev_reset_n: 1'b1, default: '0};

    ctrl_type         q;
    ctrl_type         next_q;
    logic [PIN_W-1:0] pins_s;
    logic             abort_s;
    logic             low_s;
    logic             in_ctrl;
    logic             dev_ready;

    flash_pin_sync #(
        .WIDTH (PIN_W)
    ) u_pin_sync (
        .clk   (clk),
        .nrst  (nrst),
        .ce    (ce),
        .pin   ({low_power, low_speed, abort_irq}),
        .level (pins_s)
    );

    assign abort_s   = pins_s[PIN_ABORT];
    assign low_s     = pins_s[PIN_LOSPD] | pins_s[PIN_LOPWR];
    assign in_ctrl   = (cmd_addr >= CTRL_BLK_LO) && (cmd_addr <= CTRL_BLK_HI);
    assign dev_ready = (dev_rdata & READY_MASK) != ZERO_WORD;

    always_comb
    begin
        next_q             = q;
        next_q.dev_wr      = 1'b0;
        next_q.dev_rd      = 1'b0;
        next_q.done        = 1'b0;
        next_q.dev_reset_n = !(rst_req && !q.rw_on);
        case (q.st)
            S_IDLE:
            begin
                if (cmd_valid)
                begin
                    next_q.op      = cmd_op;
                    next_q.cur_op  = cmd_op;
                    next_q.mode    = cmd_mode;
                    next_q.addr    = cmd_addr;
                    next_q.data    = cmd_data;
                    next_q.retries = '0;
                    next_q.recover = 1'b0;
                    next_q.aborted = 1'b0;
                    next_q.fail    = FAIL_NONE;
                    if (low_s)
                    begin
                        next_q.fail = FAIL_LOWPWR;
                        next_q.done = 1'b1;
                    end
                    else if (!cmd_mode && !vec_in_ram)
                    begin
                        next_q.fail = FAIL_VECTOR;
                        next_q.done = 1'b1;
                    end
                    else if (cmd_mode && in_ctrl)
                    begin
                        next_q.fail = FAIL_PROTECT;
                        next_q.done = 1'b1;
                    end
                    else
                        next_q.st = S_CHK;
                end
                else if (df_req)
                    next_q.st = S_DF;
            end
            S_DF:
            begin
                // only reachable from idle, so rewrite mode is off
                next_q.dev_wr    = 1'b1;
                next_q.dev_addr  = DF_MODE_OFS;
                next_q.dev_wdata = df_enable ? PE_EN_MASK : ZERO_WORD;
                next_q.done      = 1'b1;
                next_q.st        = S_IDLE;
            end
            S_CHK:
            begin
                next_q.dev_rd   = 1'b1;
                next_q.dev_addr = DF_MODE_OFS;
                next_q.st       = S_CHK_RD;
            end
            S_CHK_RD:
            begin
                if ((dev_rdata & PE_EN_MASK) != ZERO_WORD)
                begin
                    next_q.fail = FAIL_DFLASH;
                    next_q.done = 1'b1;
                    next_q.st   = S_IDLE;
                end
                else
                    next_q.st = S_ENABLE;
            end
            S_ENABLE:
            begin
                next_q.dev_wr    = 1'b1;
                next_q.dev_addr  = REWRITE_OFS;
                next_q.dev_wdata = RW_EN_MASK;
                next_q.rw_on     = 1'b1;
                next_q.st        = S_MODE;
            end
            S_MODE:
            begin
                next_q.dev_wr    = 1'b1;
                next_q.dev_addr  = MODE0_OFS;
                next_q.dev_wdata = q.mode ? PE_EN_MASK : ZERO_WORD;
                next_q.st        = q.recover ? S_LBD : S_ADDR;
            end
            S_LBD:
            begin
                // lock bits of an interrupted erase are unknown, so unlock
                next_q.dev_wr    = 1'b1;
                next_q.dev_addr  = MODE1_OFS;
                next_q.dev_wdata = UNLOCK_MASK;
                next_q.st        = S_ADDR;
            end
            S_ADDR:
            begin
                next_q.dev_wr    = 1'b1;
                next_q.dev_addr  = CMD_ADDR_OFS;
                next_q.dev_wdata = DATA_W'(q.addr);
                next_q.st        = S_DATA;
            end
            S_DATA:
            begin
                next_q.dev_wr    = 1'b1;
                next_q.dev_addr  = CMD_DATA_OFS;
                next_q.dev_wdata = q.data;
                next_q.st        = S_OP;
            end
            S_OP:
            begin
                next_q.dev_wr    = 1'b1;
                next_q.dev_addr  = CMD_OP_OFS;
                next_q.dev_wdata = DATA_W'(q.cur_op);
                next_q.timer     = TIMER_W'(TIMEOUT_CYCLES);
                next_q.st        = S_POLL;
            end
            S_POLL:
            begin
                next_q.dev_rd   = 1'b1;
                next_q.dev_addr = STATUS_OFS;
                next_q.st       = S_POLL_RD;
            end
            S_POLL_RD:
            begin
                if (dev_ready)
                begin
                    if ((dev_rdata & ERROR_MASK) != ZERO_WORD)
                    begin
                        next_q.fail = FAIL_DEVICE;
                        next_q.st   = S_FINISH;
                    end
                    else if (q.recover && (q.cur_op != q.op))
                    begin
                        next_q.cur_op  = q.op;
                        next_q.recover = 1'b0;
                        next_q.st      = S_ADDR;
                    end
                    else
                    begin
                        next_q.recover = 1'b0;
                        next_q.st      = S_FINISH;
                    end
                end
                else if (q.timer == '0)
                begin
                    next_q.fail = FAIL_TIMEOUT;
                    next_q.st   = S_FINISH;
                end
                else
                begin
                    next_q.timer = q.timer - 1'b1;
                    next_q.st    = S_POLL;
                end
            end
            S_ABORT:
            begin
                // device is in read array mode until the interrupt is gone
                if (!abort_s)
                begin
                    if (q.retries == RETRY_W'(MAX_RETRY))
                    begin
                        next_q.fail = FAIL_ABORTS;
                        next_q.st   = S_FINISH;
                    end
                    else
                    begin
                        next_q.retries = q.retries + 1'b1;
                        next_q.recover = 1'b1;
                        next_q.cur_op  = OP_ERASE;
                        next_q.st      = S_MODE;
                    end
                end
            end
            S_FINISH:
            begin
                next_q.dev_wr    = 1'b1;
                next_q.dev_addr  = REWRITE_OFS;
                next_q.dev_wdata = ZERO_WORD;
                next_q.rw_on     = 1'b0;
                next_q.done      = 1'b1;
                next_q.st        = S_IDLE;
            end
            default:
                next_q.st = S_IDLE;
        endcase
        // mode register 0 and ready status are lost, the sequence restarts;
        // a ready read just before the synchronised abort must not end the command
        if (abort_s && q.rw_on && (q.st != S_ABORT) && ((q.st != S_FINISH) || (q.fail == FAIL_NONE)))
        begin
            next_q.st      = S_ABORT;
            next_q.aborted = 1'b1;
            next_q.rw_on   = 1'b1;
            next_q.done    = 1'b0;
            next_q.dev_wr  = 1'b0;
            next_q.dev_rd  = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            q <= CTRL_RESET;
        else if (ce)
            q <= next_q;
    end

    assign cmd_ready    = ce && (q.st == S_IDLE);
    assign df_ready     = ce && (q.st == S_IDLE) && !cmd_valid;
    assign done         = q.done;
    assign fail         = q.fail;
    assign aborted      = q.aborted;
    assign busy         = q.st != S_IDLE;
    assign rewrite_on   = q.rw_on;
    assign trap_inhibit = q.rw_on && !q.mode;
    assign vec_irq_mask = q.rw_on && q.mode;
    assign wdt_allow    = !(q.rw_on && q.mode);
    assign dev_addr     = q.dev_addr;
    assign dev_wdata    = q.dev_wdata;
    assign dev_wr       = q.dev_wr;
    assign dev_rd       = q.dev_rd;
    assign dev_reset_n  = q.dev_reset_n;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_low_refuse;
        (ce && q.st == S_IDLE && cmd_valid && low_s) |=> (q.st == S_IDLE && q.fail == FAIL_LOWPWR && q.done);
    endproperty
    a_low_refuse: assert property (p_low_refuse) else $error("rewrite started in low power");

    property p_df_refuse;
        (ce && q.st == S_CHK_RD && (dev_rdata & PE_EN_MASK) != ZERO_WORD) |=> (q.st == S_IDLE && q.fail == FAIL_DFLASH);
    endproperty
    a_df_refuse: assert property (p_df_refuse) else $error("rewrite enabled over data-flash");

    property p_df_write;
        (dev_wr && dev_addr == DF_MODE_OFS) |-> !q.rw_on;
    endproperty
    a_df_write: assert property (p_df_write) else $error("data-flash enable written in rewrite");

    property p_abort_stop;
        (ce && abort_s && q.rw_on && q.st != S_ABORT && (q.st != S_FINISH || q.fail == FAIL_NONE))
            |=> (q.st == S_ABORT && !dev_wr && !done);
    endproperty
    a_abort_stop: assert property (p_abort_stop) else $error("abort not followed");

    property p_retry_erase;
        (ce && q.st == S_ABORT && !abort_s && q.retries != RETRY_W'(MAX_RETRY))
            |=> (q.cur_op == OP_ERASE && q.recover && q.st == S_MODE);
    endproperty
    a_retry_erase: assert property (p_retry_erase) else $error("retry does not erase first");

    property p_unlock;
        (ce && q.st == S_ABORT && !abort_s && q.retries != RETRY_W'(MAX_RETRY)) ##1 (ce && !abort_s)[*2]
            |=> (dev_wr && dev_addr == MODE1_OFS && dev_wdata == UNLOCK_MASK);
    endproperty
    a_unlock: assert property (p_unlock) else $error("lock protection not disabled");

    property p_mode_one;
        (ce && q.st == S_ABORT && !abort_s && q.mode && q.retries != RETRY_W'(MAX_RETRY)) ##1 (ce && !abort_s)
            |=> (dev_wr && dev_addr == MODE0_OFS && dev_wdata == PE_EN_MASK);
    endproperty
    a_mode_one: assert property (p_mode_one) else $error("mode one not restored");

    property p_vec_mask;
        (q.rw_on && q.mode) |-> (vec_irq_mask && !wdt_allow && !trap_inhibit);
    endproperty
    a_vec_mask: assert property (p_vec_mask) else $error("interrupts open in mode one");

    property p_ctrl_block;
        (ce && q.st == S_IDLE && cmd_valid && !low_s && cmd_mode && in_ctrl) |=> (q.fail == FAIL_PROTECT && q.st == S_IDLE);
    endproperty
    a_ctrl_block: assert property (p_ctrl_block) else $error("control block rewritten");

    property p_no_reset;
        (ce && rst_req && q.rw_on) |=> dev_reset_n;
    endproperty
    a_no_reset: assert property (p_no_reset) else $error("reset during rewrite");

    property p_timeout;
        (ce && q.st == S_POLL_RD && !dev_ready && q.timer == '0 && !abort_s) |=> (q.fail == FAIL_TIMEOUT && q.st == S_FINISH);
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout missed");

endmodule : flash_rewrite_control
`default_nettype wire

// *** verif/flash_device_model.sv ***
// device stand-in: register file, command busy time, abort handling and misuse count
// assumes one-cycle dev_wr/dev_rd pulses and a read answered in the dev_rd cycle
`timescale 1ns/1ns
`default_nettype none
module flash_device_model
    import flash_rewrite_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic [ADDR_W-1:0] dev_addr,
    input  wire logic [DATA_W-1:0] dev_wdata,
    input  wire logic              dev_wr,
    input  wire logic              dev_rd,
    output logic      [DATA_W-1:0] dev_rdata,
    input  wire logic              dev_reset_n,
    input  wire logic              abort_irq,
    input  wire logic              slow,
    input  wire logic [15:0]       latency,
    input  wire logic              err_inject
);
    logic [DATA_W-1:0] regs [8];
    logic [15:0]       busy_cnt;
    logic              err;
    logic              need_fix;
    logic              fix_one;
    logic              lock_bits;
    logic [DATA_W-1:0] fix_addr;
    logic [DATA_W-1:0] pat;
    int                viol;
    wire  [2:0]        idx = dev_addr[4:2];

    // outside a read the bus shows a changing pattern, never the last word
    assign dev_rdata = !dev_rd ? pat : idx == 3'h3 ? {30'h0, err, busy_cnt == 16'h0} : regs[idx];

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < 8; i++)
                regs[i] <= 32'h0;
            {busy_cnt, err, need_fix, fix_one, lock_bits} <= 20'h0;
            pat  <= 32'h5A5A_A5A5;
            fix_addr <= 32'h0;
            viol <= 0;
        end
        else
        begin
            pat <= ~pat + 32'h1;
            if (busy_cnt != 16'h0)
                busy_cnt <= busy_cnt - 16'h1;
            if (!dev_reset_n && regs[0][0])
                viol <= viol + 1;
            if (abort_irq)
            begin
                // read array mode: command dropped, writes ignored
                busy_cnt <= 16'h0;
                regs[1]  <= 32'h0;
                err      <= 1'b0;
                if (busy_cnt != 16'h0)
                begin
                    need_fix <= 1'b1;
                    fix_one  <= regs[1][0];
                    fix_addr <= regs[5];
                    if (regs[7][1:0] == OP_ERASE)
                        lock_bits <= 1'bx;
                end
            end
            else if (dev_wr)
            begin
                regs[idx] <= dev_wdata;
                if (idx == 3'h0 && dev_wdata[0] && (slow || regs[4][0]))
                    viol <= viol + 1;
                if (idx == 3'h4 && dev_wdata[0] && regs[0][0])
                    viol <= viol + 1;
                if (idx == 3'h7)
                begin
                    busy_cnt <= latency;
                    err      <= err_inject;
                    // only the interrupted block owes an erase first
                    if (need_fix && regs[5] == fix_addr &&
                        (dev_wdata[1:0] != OP_ERASE || !regs[2][0] || (fix_one && !regs[1][0])))
                        viol <= viol + 1;
                    if (dev_wdata[1:0] == OP_ERASE)
                        need_fix <= 1'b0;
                end
            end
        end
    end
endmodule : flash_device_model
`default_nettype wire

// *** verif/testbench.sv ***
// self-checking bench: user side driven here, device model on the register port
// assumes one 25 MHz clock and an active-low asynchronous reset
`timescale 1ns/1ns
`default_nettype none
module testbench
    import flash_rewrite_pkg::*;
;
    localparam int TMO = 20;
    localparam int MR  = 2;
    localparam logic [FADDR_W-1:0] BLK_LO = 24'hFF0000;
    localparam logic [FADDR_W-1:0] BLK_HI = 24'hFFFFFF;
    logic               clk = 1'b0, nrst = 1'b0, cmd_valid = 1'b0, cmd_mode = 1'b0, df_req = 1'b0;
    logic               df_enable = 1'b0, vec_in_ram = 1'b1, rst_req = 1'b0, abort_irq = 1'b0;
    logic               low_speed = 1'b0, low_power = 1'b0, err_inject = 1'b0;
    logic [1:0]         cmd_op = 2'h0;
    logic [FADDR_W-1:0] cmd_addr = 24'h0, a;
    logic [DATA_W-1:0]  cmd_data = 32'h0, dev_wdata, dev_rdata, r;
    logic [15:0]        latency = 16'h000A;
    logic               cmd_ready, df_ready, done, aborted, busy, rewrite_on, trap_inhibit, vec_irq_mask;
    logic               wdt_allow, dev_wr, dev_rd, dev_reset_n;
    logic [2:0]         fail;
    logic [ADDR_W-1:0]  dev_addr;
    logic [31:0]        seed = 32'h0000_569E;
    int                 error_cnt = 0, total_checks = 0;

    flash_rewrite_control #(.TIMEOUT_CYCLES(TMO), .MAX_RETRY(MR), .CTRL_BLK_LO(BLK_LO), .CTRL_BLK_HI(BLK_HI))
    flash_rewrite_control_i (.clk, .nrst, .ce(1'b1), .cmd_valid, .cmd_ready, .cmd_op, .cmd_mode, .cmd_addr,
        .cmd_data, .df_req, .df_enable, .df_ready, .vec_in_ram, .rst_req, .done, .fail, .aborted, .busy,
        .rewrite_on, .trap_inhibit, .vec_irq_mask, .wdt_allow, .dev_addr, .dev_wdata, .dev_wr, .dev_rd,
        .dev_rdata, .dev_reset_n, .abort_irq, .low_speed, .low_power);
    flash_device_model flash_device_model_i (.clk, .nrst, .dev_addr, .dev_wdata, .dev_wr, .dev_rd, .dev_rdata,
        .dev_reset_n, .abort_irq, .slow(low_speed | low_power), .latency, .err_inject);

    always #20 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic int exp_fail(int md, int ad, int slow, int vram, int dfen, int err, int lat, int ab);
        if (slow) return 1;
        if (md == 0 && !vram) return 3;
        if (md == 1 && ad >= BLK_LO && ad <= BLK_HI) return 4;
        if (dfen) return 2;
        if (ab > MR) return 7;
        if (lat > 2 * TMO) return 6;
        return err ? 5 : 0;
    endfunction : exp_fail

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk

    task automatic step();
        @(posedge clk);
        #1;
    endtask : step

    task automatic run_cmd(input logic [1:0] op, input logic md, input logic [FADDR_W-1:0] ad,
                           input logic [DATA_W-1:0] dt, input int ef, input logic ea);
        int n;
        step();
        {cmd_valid, cmd_op, cmd_mode, cmd_addr, cmd_data} = {1'b1, op, md, ad, dt};
        while (cmd_ready !== 1'b1)
            step();
        step();
        cmd_valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 3000)
        begin
            if (rewrite_on === 1'b1)
            begin
                chk("dev_reset_n", 1, dev_reset_n);
                chk("trap_inhibit", !md, trap_inhibit);
                chk("vec_irq_mask", md, vec_irq_mask);
                chk("wdt_allow", !md, wdt_allow);
                chk("busy", 1, busy);
            end
            step();
            n++;
        end
        chk("done", 1, done);
        chk("busy", 0, busy);
        chk("fail", ef, fail);
        chk("aborted", ea, aborted);
        if (ef >= 1 && ef <= 4)
            chk("refuse_cycles", ef == 2 ? 2 : 0, n);
        step();
        chk("done_len", 0, done);
        if (ef == 0)
        begin
            chk("addr_reg", ad, flash_device_model_i.regs[5]);
            chk("data_reg", dt, flash_device_model_i.regs[6]);
            chk("op_reg", op, flash_device_model_i.regs[7]);
            chk("rewrite_reg", 0, flash_device_model_i.regs[0]);
        end
    endtask : run_cmd

    task automatic df_write(input logic v);
        step();
        {df_req, df_enable} = {1'b1, v};
        while (df_ready !== 1'b1)
            step();
        step();
        df_req = 1'b0;
        step();
        chk("df_done", 1, done);
        step();
        chk("df_reg", v, flash_device_model_i.regs[4]);
    endtask : df_write

    task automatic pulse_abort(input int after, input int times);
        repeat (after) step();
        repeat (times)
        begin
            abort_irq = 1'b1;
            repeat (3) step();
            abort_irq = 1'b0;
            repeat (12) step();
        end
    endtask : pulse_abort

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    initial
    begin
        #(40 * 40000);
        error_cnt++;
        give_verdict();
    end

    initial
    begin
        repeat (2) @(posedge clk);
        #1 nrst = 1'b1;
        for (int i = 0; i < 8; i++)
            run_cmd(i[1:0], i[2], 24'h000400 * i, rnd(), exp_fail(i / 4, 'h400 * i, 0, 1, 0, 0, 10, 0), 1'b0);
        $display("test codes done");
        df_write(1'b1);
        run_cmd(OP_PROGRAM, 1'b0, 24'h000010, 32'h1, exp_fail(0, 'h10, 0, 1, 1, 0, 10, 0), 1'b0);
        df_write(1'b0);
        $display("test data_flash done");
        err_inject = 1'b1;
        run_cmd(OP_LOCK, 1'b0, 24'h000020, 32'h2, exp_fail(0, 'h20, 0, 1, 0, 1, 10, 0), 1'b0);
        err_inject = 1'b0;
        latency = 16'h00C8;
        run_cmd(OP_PROTECT, 1'b1, 24'h000030, 32'h3, exp_fail(1, 'h30, 0, 1, 0, 0, 200, 0), 1'b0);
        latency = 16'h000A;
        $display("test status done");
        for (int m = 0; m < 2; m++)
        begin
            fork
                run_cmd(OP_PROGRAM, m[0], 24'h002000, rnd(), exp_fail(m, 'h2000, 0, 1, 0, 0, 10, 1), 1'b1);
                pulse_abort(13, 1);
            join
            chk("lock_disable", 1, flash_device_model_i.regs[2]);
        end
        latency = 16'h0018;
        fork
            run_cmd(OP_ERASE, 1'b0, 24'h003000, 32'h4, exp_fail(0, 'h3000, 0, 1, 0, 0, 24, 3), 1'b1);
            pulse_abort(13, 3);
        join
        $display("test abort done");
        fork
            run_cmd(OP_PROGRAM, 1'b0, 24'h004000, 32'h5, 0, 1'b0);
            begin
                repeat (14) step();
                rst_req = 1'b1;
            end
        join
        repeat (2) step();
        chk("dev_reset_n", 0, dev_reset_n);
        rst_req = 1'b0;
        repeat (2) step();
        chk("dev_reset_n", 1, dev_reset_n);
        latency = 16'h000A;
        $display("test device_reset done");
        for (int i = 0; i < 16; i++)
        begin
            r = rnd();
            {low_speed, low_power, vec_in_ram} = {r[5] & r[6], r[7] & r[8], r[3] | r[4]};
            a = r[10] ? {8'hFF, r[31:16]} : r[31:8];
            repeat (3) step();
            run_cmd(r[1:0], r[2], a, rnd(), exp_fail(r[2], a, low_speed | low_power, vec_in_ram, 0, 0, 10, 0),
                    1'b0);
        end
        $display("test random done");
        chk("misuse", 0, flash_device_model_i.viol);
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
